// [rtl/ram_address_pointer_dma_ctrl.sv]
// Buffer RAM host port: pointer registers, data window, DMA handshake, swap.
// Assumes inputs synchronous to aclk and a well-behaved AXI4-Lite master.
//
// What this block does
// - Direction bit high means DMA transfers read the RAM, low means they write it; host data accesses ignore it.
// - Step bit set advances pointer after each data access; clear keeps it.
// - Pointer high bits 5 and 4 are reserved and read back as zero.
// - Address bits 10 to 8 come from pointer high bits 2 to 0.
// - Address bits 7 to 0 come from the whole pointer low register.
// - With DMA enable set, writing pointer low raises the DMA request.
// - Clearing DMA enable mid-transfer drops the request immediately.
// - After such a clear, transfer ends after the next acknowledge fall.
// - Finished source output is low in reset, then the inverse of the DMA enable bit.
// - Hardware clears DMA enable when the transfer completes.
// - Completion raises the interrupt when its mask bit enables it.
// - Swap control resets to zero, like the other bus control bits.
// - Strobe mode, swap 0: odd byte upper lanes; direction mode opposite.
// - Swap applies to host accesses and DMA transfers alike in wide mode.
// - Command byte 0x10 clears the completion mask, clearing the interrupt.
`timescale 1ns/1ps

module ram_address_pointer_dma_ctrl #(
   parameter int depth = ram_port_pkg::ram_depth
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic awvalid,
   output logic awready,
   input wire logic [4:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [4:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // DMA handshake and data
   output logic dma_request_out,
   input wire logic dma_acknowledge_in,
   input wire logic [15:0] dma_wdata_in,
   output logic [15:0] dma_rdata_out,
   // Interrupt
   output logic dma_finished_source,
   output logic irq
);

   ram_port_pkg::port_state_type s;
   ram_port_pkg::port_state_type next_s;
   logic [7:0] ram [depth];
   logic [1:0] ram_we;
   logic [9:0] ram_pair;
   logic [7:0] ram_even;
   logic [7:0] ram_odd;

   // Lane order for the current mode
   function automatic logic hi_is_odd(input ram_port_pkg::port_state_type st);
      hi_is_odd = st.strobe_mode ^ st.swap;
   endfunction

   function automatic logic [10:0] step_of(input ram_port_pkg::port_state_type st);
      step_of = st.wide_bus_enable ? ram_port_pkg::step_word : ram_port_pkg::step_byte;
   endfunction

   // Data word as seen by the host or DMA for the prefetched pair
   function automatic logic [15:0] out_word(input ram_port_pkg::port_state_type st);
      if (!st.wide_bus_enable) begin
         out_word = {8'h00, st.ptr[0] ? st.pf_odd : st.pf_even};
      end else if (hi_is_odd(st)) begin
         out_word = {st.pf_odd, st.pf_even};
      end else begin
         out_word = {st.pf_even, st.pf_odd};
      end
   endfunction

   always_comb begin
      logic [15:0] wr_word;
      logic [7:0] wb;
      logic ack_rise;
      logic ack_fall;
      logic done_event;
      wr_word = 16'h0000;
      wb = 8'h00;
      ack_rise = dma_acknowledge_in & ~s.ack_prev;
      ack_fall = ~dma_acknowledge_in & s.ack_prev;
      done_event = 1'b0;
      next_s = s;
      ram_we = 2'h0;
      ram_pair = s.ptr[10:1];
      ram_even = 8'h00;
      ram_odd = 8'h00;

      // Refresh prefetch after any pointer or RAM change
      if (s.pending) begin
         next_s.pf_even = ram[{s.ptr[10:1], 1'b0}];
         next_s.pf_odd = ram[{s.ptr[10:1], 1'b1}];
         next_s.pending = 1'b0;
      end

      // Channel handshakes
      if (awvalid && s.awready) begin
         next_s.aw_held = 1'b1;
         next_s.awaddr = awaddr;
      end
      if (wvalid && s.wready) begin
         next_s.w_held = 1'b1;
         next_s.wdata = wdata;
         next_s.wbyte0 = wstrb[0];
      end
      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
      end
      if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
      end

      // Register write once address and data are both held
      if (s.aw_held && s.w_held && !s.bvalid) begin
         next_s.aw_held = 1'b0;
         next_s.w_held = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = ram_port_pkg::resp_okay;
         wb = s.wdata[7:0];
         unique case (s.awaddr)
            ram_port_pkg::off_ptr_high: begin
               if (s.wbyte0) begin
                  next_s.next_access_is_read = wb[ram_port_pkg::pos_read_dir];
                  next_s.pointer_step_enable = wb[ram_port_pkg::pos_step_en];
                  next_s.dma_request_enable = wb[ram_port_pkg::pos_dma_en];
                  next_s.ptr[10:8] = wb[ram_port_pkg::pos_upper_hi:0];
                  next_s.pending = 1'b1;
               end
            end
            ram_port_pkg::off_ptr_low: begin
               if (s.wbyte0) begin
                  next_s.ptr[7:0] = wb;
                  next_s.pending = 1'b1;
                  if (s.dma_request_enable) begin
                     next_s.dma_active = 1'b1;
                     next_s.dma_req = 1'b1;
                     next_s.dma_last = 1'b0;
                  end
               end
            end
            ram_port_pkg::off_data: begin
               if (s.wide_bus_enable) begin
                  wr_word = s.wdata[15:0];
                  ram_we = 2'h3;
                  ram_odd = hi_is_odd(s) ? wr_word[15:8] : wr_word[7:0];
                  ram_even = hi_is_odd(s) ? wr_word[7:0] : wr_word[15:8];
               end else begin
                  ram_we = s.ptr[0] ? 2'h2 : 2'h1;
                  ram_odd = wb;
                  ram_even = wb;
               end
               if (s.pointer_step_enable) begin
                  next_s.ptr = s.ptr + step_of(s);
               end
               next_s.pending = 1'b1;
            end
            ram_port_pkg::off_bus_ctrl: begin
               if (s.wbyte0) begin
                  next_s.wide_bus_enable = wb[ram_port_pkg::pos_wide];
                  next_s.swap = wb[ram_port_pkg::pos_swap];
                  next_s.strobe_mode = wb[ram_port_pkg::pos_strobe];
               end
            end
            ram_port_pkg::off_irq_status: begin
               if (s.wbyte0 && wb[ram_port_pkg::pos_dma_done]) begin
                  next_s.status = 1'b0;
               end
            end
            ram_port_pkg::off_irq_mask: begin
               if (s.wbyte0) begin
                  next_s.mask = wb[ram_port_pkg::pos_dma_done];
               end
            end
            ram_port_pkg::off_command: begin
               if (s.wbyte0 && wb == ram_port_pkg::cmd_clear_dma_mask) begin
                  next_s.mask = 1'b0;
               end
            end
            ram_port_pkg::off_dma_count: begin
               next_s.dma_count = s.wdata[10:0];
            end
            default: begin
               next_s.bresp = ram_port_pkg::resp_slverr;
            end
         endcase
      end

      // Register read
      if (arvalid && s.arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = ram_port_pkg::resp_okay;
         next_s.rdata = 32'h0000_0000;
         unique case (araddr)
            ram_port_pkg::off_ptr_high: begin
               next_s.rdata[ram_port_pkg::pos_read_dir] = s.next_access_is_read;
               next_s.rdata[ram_port_pkg::pos_step_en] = s.pointer_step_enable;
               next_s.rdata[ram_port_pkg::pos_dma_en] = s.dma_request_enable;
               next_s.rdata[2:0] = s.ptr[10:8];
            end
            ram_port_pkg::off_ptr_low: begin
               next_s.rdata[7:0] = s.ptr[7:0];
            end
            ram_port_pkg::off_data: begin
               next_s.rdata[15:0] = out_word(s);
               if (s.pointer_step_enable) begin
                  next_s.ptr = s.ptr + step_of(s);
               end
               next_s.pending = 1'b1;
            end
            ram_port_pkg::off_bus_ctrl: begin
               next_s.rdata[ram_port_pkg::pos_wide] = s.wide_bus_enable;
               next_s.rdata[ram_port_pkg::pos_swap] = s.swap;
               next_s.rdata[ram_port_pkg::pos_strobe] = s.strobe_mode;
            end
            ram_port_pkg::off_irq_status: begin
               next_s.rdata[ram_port_pkg::pos_dma_done] = s.status;
            end
            ram_port_pkg::off_irq_mask: begin
               next_s.rdata[ram_port_pkg::pos_dma_done] = s.mask;
            end
            ram_port_pkg::off_command: begin
               next_s.rdata = 32'h0000_0000;
            end
            ram_port_pkg::off_dma_count: begin
               next_s.rdata[10:0] = s.dma_count;
            end
            default: begin
               next_s.rresp = ram_port_pkg::resp_slverr;
            end
         endcase
      end

      // Transfer engine: one item per acknowledge rise
      next_s.ack_prev = dma_acknowledge_in;
      if (s.dma_active && ack_rise && !s.dma_last) begin
         if (s.next_access_is_read) begin
            next_s.dma_rdata = out_word(s);
         end else if (s.wide_bus_enable) begin
            ram_we = 2'h3;
            ram_odd = hi_is_odd(s) ? dma_wdata_in[15:8] : dma_wdata_in[7:0];
            ram_even = hi_is_odd(s) ? dma_wdata_in[7:0] : dma_wdata_in[15:8];
         end else begin
            ram_we = s.ptr[0] ? 2'h2 : 2'h1;
            ram_odd = dma_wdata_in[7:0];
            ram_even = dma_wdata_in[7:0];
         end
         if (s.pointer_step_enable) begin
            next_s.ptr = s.ptr + step_of(s);
         end
         next_s.pending = 1'b1;
         if (s.dma_count == 11'h000) begin
            next_s.dma_last = 1'b1;
            next_s.dma_req = 1'b0;
         end else begin
            next_s.dma_count = s.dma_count - 11'h001;
         end
      end
      if (s.dma_active && ack_fall && (s.dma_last || !s.dma_request_enable)) begin
         next_s.dma_active = 1'b0;
         next_s.dma_last = 1'b0;
         next_s.dma_req = 1'b0;
         next_s.dma_request_enable = 1'b0;
         done_event = 1'b1;
      end

      // Request never outlives a cleared enable
      next_s.dma_req = next_s.dma_req & next_s.dma_request_enable;
      next_s.dma_fin_src = ~next_s.dma_request_enable;

      // Sticky completion flag, set wins over clear
      if (done_event) begin
         next_s.status = 1'b1;
      end
      next_s.irq = next_s.status & next_s.mask;

      // Channel readiness
      // Both channels stay closed until the response is taken
      next_s.awready = ~next_s.aw_held & ~next_s.bvalid;
      next_s.wready = ~next_s.w_held & ~next_s.bvalid;
      next_s.arready = ~next_s.rvalid & ~next_s.pending;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Buffer RAM, even and odd bytes of the addressed pair
   always_ff @(posedge aclk) begin
      if (ram_we[0]) begin
         ram[{ram_pair, 1'b0}] <= ram_even;
      end
      if (ram_we[1]) begin
         ram[{ram_pair, 1'b1}] <= ram_odd;
      end
   end

   assign awready = s.awready;
   assign wready = s.wready;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = s.arready;
   assign rvalid = s.rvalid;
   assign rdata = s.rdata;
   assign rresp = s.rresp;
   assign dma_request_out = s.dma_req;
   assign dma_rdata_out = s.dma_rdata;
   assign dma_finished_source = s.dma_fin_src;
   assign irq = s.irq;

endmodule // ram_address_pointer_dma_ctrl

// [inc/ram_port_pkg.sv]
// Constants, register map and state layout for the buffer RAM host port.
// Assumes a 32-bit AXI4-Lite bus with 5 address bits decoded.
package ram_port_pkg;

   // Buffer geometry
   localparam int ram_addr_w = 11;
   localparam int ram_depth = 2048;
   localparam int axi_addr_w = 5;

   // Register byte offsets
   localparam logic [4:0] off_ptr_high = 5'h00;
   localparam logic [4:0] off_ptr_low = 5'h04;
   localparam logic [4:0] off_data = 5'h08;
   localparam logic [4:0] off_bus_ctrl = 5'h0C;
   localparam logic [4:0] off_irq_status = 5'h10;
   localparam logic [4:0] off_irq_mask = 5'h14;
   localparam logic [4:0] off_command = 5'h18;
   localparam logic [4:0] off_dma_count = 5'h1C;

   // Pointer high fields
   localparam int pos_read_dir = 7;
   localparam int pos_step_en = 6;
   localparam int pos_dma_en = 3;
   localparam int pos_upper_hi = 2;

   // Bus control fields
   localparam int pos_wide = 0;
   localparam int pos_swap = 1;
   localparam int pos_strobe = 2;

   // Interrupt status and mask fields
   localparam int pos_dma_done = 0;

   // Command byte that clears the end-of-transfer mask bit
   localparam logic [7:0] cmd_clear_dma_mask = 8'h10;

   // Responses
   localparam logic [1:0] resp_okay = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;

   // Pointer step sizes
   localparam logic [10:0] step_byte = 11'h001;
   localparam logic [10:0] step_word = 11'h002;

   typedef struct packed {
      // Write channel
      logic awready;
      logic aw_held;
      logic [4:0] awaddr;
      logic wready;
      logic w_held;
      logic [31:0] wdata;
      logic wbyte0;
      logic bvalid;
      logic [1:0] bresp;
      // Read channel
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      // Pointer and control
      logic next_access_is_read;
      logic pointer_step_enable;
      logic dma_request_enable;
      logic [10:0] ptr;
      logic wide_bus_enable;
      logic swap;
      logic strobe_mode;
      logic [10:0] dma_count;
      // Prefetch
      logic pending;
      logic [7:0] pf_even;
      logic [7:0] pf_odd;
      // Transfer engine
      logic dma_active;
      logic dma_last;
      logic ack_prev;
      logic dma_req;
      logic [15:0] dma_rdata;
      logic dma_fin_src;
      // Interrupts
      logic status;
      logic mask;
      logic irq;
   } port_state_type;

endpackage

// [dv/ram_port_checker_assertions.sv]
// Pin-level checker for the buffer RAM host port.
// Assumes one clock aclk and synchronous active-low aresetn.
`timescale 1ns/1ps
module ram_port_checker (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshakes
   input wire logic awready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   // Transfer and interrupt
   input wire logic dma_request_out,
   input wire logic dma_acknowledge_in,
   input wire logic dma_finished_source,
   input wire logic irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wrote;
      bvalid || $past(bvalid);
   endsequence
   sequence s_acked;
      $past(dma_acknowledge_in) || $past(dma_acknowledge_in, 2);
   endsequence
   property p_req_en;
      dma_request_out |-> !dma_finished_source;
   endproperty
   a_req_en: assert property (p_req_en) else $error("request while disabled");
   property p_req_rise;
      $rose(dma_request_out) |-> s_wrote;
   endproperty
   a_req_rise: assert property (p_req_rise) else $error("request without write");
   property p_src_change;
      $changed(dma_finished_source) |-> s_wrote or s_acked or $past(!aresetn);
   endproperty
   a_src_change: assert property (p_src_change) else $error("source moved alone");
   property p_irq_done;
      $rose(irq) |-> dma_finished_source;
   endproperty
   a_irq_done: assert property (p_irq_done) else $error("irq before end");
   property p_b_done;
      bvalid && bready |=> !bvalid;
   endproperty
   a_b_done: assert property (p_b_done) else $error("write response repeated");
   property p_r_done;
      rvalid && rready |=> !rvalid;
   endproperty
   a_r_done: assert property (p_r_done) else $error("read response repeated");
   property p_ar_block;
      rvalid |-> !arready;
   endproperty
   a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
   property p_aw_block;
      bvalid |-> !awready;
   endproperty
   a_aw_block: assert property (p_aw_block) else $error("write taken while busy");
endmodule // ram_port_checker

bind ram_address_pointer_dma_ctrl ram_port_checker i_chk (
   .aclk(aclk), .aresetn(aresetn), .awready(awready), .bvalid(bvalid), .bready(bready),
   .arready(arready), .rvalid(rvalid), .rready(rready), .dma_request_out(dma_request_out),
   .dma_acknowledge_in(dma_acknowledge_in), .dma_finished_source(dma_finished_source),
   .irq(irq)
);

// [dv/dma_partner.sv]
// Behavioural DMA controller on the request line of the port.
// Assumes gap is steady while a transfer runs.
`timescale 1ns/1ps
module dma_partner (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Handshake
   input wire logic dma_request_out,
   output logic dma_acknowledge_in = 1'b0,
   output logic [15:0] dma_wdata_in = 16'hFFFF,
   // Pace and tally
   input wire logic [3:0] gap,
   output logic [7:0] items
);
   logic [3:0] cnt;
   always @(posedge aclk) begin
      if (!aresetn) begin
         dma_acknowledge_in <= 1'b0;
         cnt <= 4'h0;
         items <= 8'h00;
      end else if (dma_acknowledge_in) begin
         // Each item ends with a fall, even once the request is gone
         cnt <= cnt + 4'h1;
         if (cnt == 4'h1) begin
            dma_acknowledge_in <= 1'b0;
            dma_wdata_in <= ~dma_wdata_in;
            cnt <= 4'h0;
         end
      end else if (cnt < gap) begin
         cnt <= cnt + 4'h1;
      end else if (dma_request_out) begin
         dma_acknowledge_in <= 1'b1;
         dma_wdata_in <= 16'h00A0 + {8'h00, items};
         items <= items + 8'h01;
      end
   end
endmodule // dma_partner

// [dv/test_ram_address_pointer_dma_ctrl.sv]
// Self-checking bench: AXI4-Lite master tasks, DMA partner, scenarios.
// Assumes the checker binds itself into the design.
`timescale 1ns/1ps
module test_ram_address_pointer_dma_ctrl;
   localparam logic [4:0] ph = ram_port_pkg::off_ptr_high;
   localparam logic [4:0] pl = ram_port_pkg::off_ptr_low;
   localparam logic [4:0] dw = ram_port_pkg::off_data;
   localparam logic [4:0] bc = ram_port_pkg::off_bus_ctrl;
   localparam logic [4:0] st = ram_port_pkg::off_irq_status;
   localparam logic [4:0] mk = ram_port_pkg::off_irq_mask;
   localparam logic [4:0] cm = ram_port_pkg::off_command;
   localparam logic [4:0] dc = ram_port_pkg::off_dma_count;
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [4:0] awaddr = 5'h00, araddr = 5'h00;
   logic [31:0] wdata = 32'h0, d, e;
   logic [15:0] dma_rdata;
   logic awready, wready, bvalid, arready, rvalid, dma_request_out, dma_acknowledge_in;
   logic dma_finished_source, irq;
   logic [31:0] rdata;
   logic [15:0] dma_wdata_in;
   logic [3:0] gap = 4'h3;
   logic [7:0] items;
   int fail_count = 0, n_compared = 0, cyc = 0;
   always #12.5 aclk = ~aclk;
   ram_address_pointer_dma_ctrl i_dut (
      .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
      .bvalid(bvalid), .bready(bready), .bresp(), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
      .rresp(), .dma_request_out(dma_request_out), .dma_acknowledge_in(dma_acknowledge_in),
      .dma_wdata_in(dma_wdata_in), .dma_rdata_out(dma_rdata),
      .dma_finished_source(dma_finished_source),
      .irq(irq)
   );
   dma_partner i_far (
      .aclk(aclk), .aresetn(aresetn), .dma_request_out(dma_request_out),
      .dma_acknowledge_in(dma_acknowledge_in), .dma_wdata_in(dma_wdata_in), .gap(gap),
      .items(items)
   );
   task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
      n_compared++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] %0t %s: %h vs %h", $time, m, s, e);
      end
   endtask
   task automatic give_verdict;
      $display("compared %0d, failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      logic ta, tw;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ta && tw)) begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         ta = ta | (awready === 1'b1);
         tw = tw | (wready === 1'b1);
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] v);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      v = rdata;
      rready <= 1'b0;
      #1;
   endtask
   task automatic setp(input logic [7:0] h, input logic [7:0] l);
      wr(ph, {24'h0, h});
      wr(pl, {24'h0, l});
   endtask
   task automatic wait_src;
      repeat (300) if (dma_finished_source !== 1'b1) @(posedge aclk);
      #1;
   endtask
   task automatic t_reset;
      rd(ph, d);
      chk(d, 32'h0, "high reset");
      chk(dma_finished_source, 32'h1, "source");
      chk(irq, 32'h0, "irq idle");
   endtask
   task automatic t_ptr;
      wr(ph, 32'hF7);
      rd(ph, d);
      chk(d & 32'hCF, 32'hC7, "high fields");
      wr(pl, 32'hAB);
      rd(pl, d);
      chk(d, 32'hAB, "low");
   endtask
   task automatic t_seq;
      setp(8'h47, 8'h10);
      wr(dw, 32'h5A);
      wr(dw, 32'h3C);
      rd(pl, d);
      chk(d, 32'h12, "step");
      setp(8'h40, 8'h10);
      wr(dw, 32'h99);
      setp(8'hC7, 8'h10);
      rd(dw, d);
      chk(d, 32'h5A, "first");
      rd(dw, d);
      chk(d, 32'h3C, "second");
      setp(8'h87, 8'h10);
      rd(dw, d);
      rd(dw, d);
      chk(d, 32'h5A, "no step");
      rd(pl, d);
      chk(d, 32'h10, "held");
   endtask
   task automatic t_swap;
      setp(8'h40, 8'h00);
      wr(dw, 32'h11);
      wr(dw, 32'h22);
      for (int i = 0; i < 4; i++) begin
         wr(bc, 32'(i * 2));
         wr(bc, 32'(i * 2 + 1));
         setp(8'hC0, 8'h00);
         rd(dw, d);
         chk(d, (i == 1 || i == 2) ? 32'h2211 : 32'h1122, "lanes");
      end
      wr(bc, 32'h0);
   endtask
   task automatic t_dma;
      wr(mk, 32'h1);
      wr(dc, 32'h1);
      wr(ph, 32'h48);
      chk(dma_finished_source, 32'h0, "source low");
      chk(dma_request_out, 32'h0, "no request");
      wr(pl, 32'h20);
      wait_src;
      chk(items, 32'h2, "items");
      chk(irq, 32'h1, "irq");
      rd(ph, d);
      chk(d & 32'h8, 32'h0, "auto clear");
      rd(pl, d);
      chk(d, 32'h22, "dma step");
      setp(8'hC0, 8'h20);
      rd(dw, d);
      chk(d, 32'hA0, "byte 0");
      rd(dw, d);
      chk(d, 32'hA1, "byte 1");
      wr(cm, 32'h10);
      repeat (2) @(posedge aclk);
      #1;
      chk(irq, 32'h0, "irq cleared");
      wr(st, 32'h1);
      rd(st, d);
      chk(d, 32'h0, "status");
      wr(dc, 32'h0);
      wr(ph, 32'h88);
      wr(pl, 32'h20);
      wait_src;
      chk(dma_rdata, 32'hA0, "dma read");
      rd(pl, d);
      chk(d, 32'h20, "dma no step");
   endtask
   task automatic t_abort;
      gap = 4'h0;
      wr(dc, 32'h5);
      setp(8'h48, 8'h30);
      repeat (100) if (dma_acknowledge_in !== 1'b1) @(posedge aclk);
      wr(ph, 32'h40);
      chk(dma_request_out, 32'h0, "dropped");
      wait_src;
      chk(dma_finished_source, 32'h1, "ended");
      repeat (8) @(posedge aclk);
      #1;
      chk(dma_request_out, 32'h0, "idle");
      rd(pl, d);
      repeat (20) @(posedge aclk);
      rd(pl, e);
      chk(e, d, "no items after end");
   endtask
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset;
      t_ptr;
      t_seq;
      t_swap;
      t_dma;
      t_abort;
      give_verdict;
   end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         give_verdict;
      end
   end
endmodule // test_ram_address_pointer_dma_ctrl
